// ==== inc/sct_pkg.sv ====
// Shared constants and types for the sample clock trim and sync block
package sct_pkg;

  // Register word offsets
  localparam logic [7:0] SCT_OFF_RATIO_RES = 8'h0A;
  localparam logic [7:0] SCT_OFF_PERIOD_DIV = 8'h12;
  localparam logic [7:0] SCT_OFF_EXT_SYNC = 8'h38;
  localparam logic [7:0] SCT_OFF_SLOW_CTRL = 8'h4B;
  localparam logic [7:0] SCT_OFF_FAST_TRIM = 8'h4D;
  localparam logic [7:0] SCT_OFF_CONV_TIMING = 8'h4E;
  localparam logic [7:0] SCT_OFF_SYNC_CFG = 8'h4F;
  localparam logic [7:0] SCT_OFF_RATIO_CTRL = 8'h50;

  // Reset values
  localparam logic [15:0] SCT_RST_PERIOD_DIV = 16'h0028;
  localparam logic [15:0] SCT_RST_EXT_SYNC = 16'h0000;
  localparam logic [15:0] SCT_RST_SLOW_CTRL = 16'h2612;
  localparam logic [15:0] SCT_RST_FAST_TRIM = 16'h425E;
  localparam logic [15:0] SCT_RST_CONV_TIMING = 16'h0060;
  localparam logic [15:0] SCT_RST_SYNC_CFG = 16'h2090;
  localparam logic [15:0] SCT_RST_RATIO_CTRL = 16'h0000;

  // Field positions
  localparam int SCT_BIT_CLK_EN = 7;
  localparam int SCT_SLOW_TRIM_MSB = 5;
  localparam int SCT_FAST_TRIM_MSB = 7;
  localparam int SCT_BIT_EXT_SYNC_EN = 14;
  localparam int SCT_BIT_SYNC_SRC = 2;
  localparam int SCT_BIT_PIN_IE = 1;
  localparam int SCT_BIT_RATIO_START = 5;

  // Slow trim coding
  localparam logic [5:0] SCT_SLOW_TRIM_CENTRE = 6'h22;
  localparam int SCT_PERIOD_MULT = 4;

  // Timing: system clock, nominal slow clock, trim step
  localparam int SCT_CLK_HZ = 10_000_000;
  localparam int SCT_SLOW_NOM_HZ = 32_000;
  localparam int SCT_SLOW_STEP_HZ = 600;
  localparam int SCT_SLOW_CENTRE_CYC = SCT_CLK_HZ / SCT_SLOW_NOM_HZ;
  localparam int SCT_SLOW_STEP_CYC =
    SCT_CLK_HZ / (SCT_SLOW_NOM_HZ - SCT_SLOW_STEP_HZ) - SCT_SLOW_CENTRE_CYC;

  // Register write request
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } sct_wreq_t;

  // Ratio calculation states
  typedef enum logic [1:0] {
    SCT_R_IDLE = 2'b01,
    SCT_R_RUN = 2'b10
  } sct_ratio_st_t;

endpackage : sct_pkg

// ==== core/sct_core.sv ====
// Sample clock gating, trimming, sample sync selection and clock ratio calculation
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RL1: Slow sample clock runs only when enabled.
// RL2: Slow trim step shifts frequency; larger slower.
// RL3: Trim zero fastest, all ones slowest, centre 0x22.
// RL4: Fast clock trimmed per step; default 0x5E.
// RL5: Source zero: slow clock and divider time samples.
// RL6: Source one: interrupt pin triggers each sample.
// RL7: Interrupt pin input used only when enabled.
// RL8: Start bit launches ratio; result readable.
// RL9: Host clears start bit before restarting.
// RL10: Host sets external sync enable with source.
// RL11: Sample rate is slow clock over four times divider.
// RL12: Start on rising start bit; result held.
module sct_core #(
  parameter int RATIO_SLOW_TICKS = 4,
  parameter int RES_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port behind the serial interface
  input wire sct_pkg::sct_wreq_t wreq_i,
  input wire logic rd_i,
  input wire logic [7:0] rd_addr_i,
  output logic [15:0] rd_data_o,
  output logic rd_valid_o,
  // Interrupt pin input side
  input wire logic irq_pin_i,
  // Clock control outputs
  output logic slow_clk_o,
  output logic [5:0] slow_clock_trim_o,
  output logic [7:0] fast_clock_trim_o,
  output logic irq_pin_input_enable_o,
  output logic external_sync_enable_o,
  output logic sample_start_o,
  output logic ratio_busy_o
);

  // Window counter is 8 bits wide and the result must fit one register word
  if (RATIO_SLOW_TICKS < 1 || RATIO_SLOW_TICKS > 256 ||
      RES_W < 1 || RES_W > 16) begin : g_bad_param
    $error("sct_core: unsupported parameter values");
  end

  localparam int PW = 10;

  logic [15:0] period_div_q;
  logic [15:0] ext_sync_q;
  logic [15:0] slow_ctrl_q;
  logic [15:0] fast_trim_q;
  logic [15:0] conv_timing_q;
  logic [15:0] sync_cfg_q;
  logic [15:0] ratio_ctrl_q;
  logic [RES_W-1:0] ratio_res_q;

  // Register writes; reserved bits are kept as written
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      period_div_q <= sct_pkg::SCT_RST_PERIOD_DIV;
      ext_sync_q <= sct_pkg::SCT_RST_EXT_SYNC;
      slow_ctrl_q <= sct_pkg::SCT_RST_SLOW_CTRL;
      fast_trim_q <= sct_pkg::SCT_RST_FAST_TRIM;
      conv_timing_q <= sct_pkg::SCT_RST_CONV_TIMING;
      sync_cfg_q <= sct_pkg::SCT_RST_SYNC_CFG;
      ratio_ctrl_q <= sct_pkg::SCT_RST_RATIO_CTRL;
    end else if (wreq_i.wr) begin
      case (wreq_i.addr)
        sct_pkg::SCT_OFF_PERIOD_DIV: period_div_q <= wreq_i.wdata;
        sct_pkg::SCT_OFF_EXT_SYNC: ext_sync_q <= wreq_i.wdata;
        sct_pkg::SCT_OFF_SLOW_CTRL: slow_ctrl_q <= wreq_i.wdata;
        sct_pkg::SCT_OFF_FAST_TRIM: fast_trim_q <= wreq_i.wdata;
        sct_pkg::SCT_OFF_CONV_TIMING: conv_timing_q <= wreq_i.wdata;
        sct_pkg::SCT_OFF_SYNC_CFG: sync_cfg_q <= wreq_i.wdata;
        sct_pkg::SCT_OFF_RATIO_CTRL: ratio_ctrl_q <= wreq_i.wdata;
        default: ;
      endcase
    end
  end

  // Register reads answer one cycle later; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 16'h0000;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_i;
      case (rd_addr_i)
        sct_pkg::SCT_OFF_RATIO_RES: rd_data_o <= 16'(ratio_res_q); // RL8
        sct_pkg::SCT_OFF_PERIOD_DIV: rd_data_o <= period_div_q;
        sct_pkg::SCT_OFF_EXT_SYNC: rd_data_o <= ext_sync_q;
        sct_pkg::SCT_OFF_SLOW_CTRL: rd_data_o <= slow_ctrl_q;
        sct_pkg::SCT_OFF_FAST_TRIM: rd_data_o <= fast_trim_q;
        sct_pkg::SCT_OFF_CONV_TIMING: rd_data_o <= conv_timing_q;
        sct_pkg::SCT_OFF_SYNC_CFG: rd_data_o <= sync_cfg_q;
        sct_pkg::SCT_OFF_RATIO_CTRL: rd_data_o <= ratio_ctrl_q;
        default: rd_data_o <= 16'h0000;
      endcase
    end
  end

  logic clk_en;
  logic sync_src;
  logic pin_ie;
  logic [5:0] slow_trim;
  assign clk_en = slow_ctrl_q[sct_pkg::SCT_BIT_CLK_EN];
  assign sync_src = sync_cfg_q[sct_pkg::SCT_BIT_SYNC_SRC];
  assign pin_ie = sync_cfg_q[sct_pkg::SCT_BIT_PIN_IE];
  assign slow_trim = slow_ctrl_q[sct_pkg::SCT_SLOW_TRIM_MSB:0];

  // Slow tick period: centre code gives nominal, larger code longer period
  logic [PW-1:0] slow_per;
  assign slow_per = PW'(sct_pkg::SCT_SLOW_CENTRE_CYC)
    + PW'(slow_trim) * PW'(sct_pkg::SCT_SLOW_STEP_CYC)
    - PW'(sct_pkg::SCT_SLOW_TRIM_CENTRE) * PW'(sct_pkg::SCT_SLOW_STEP_CYC); // RL2 RL3

  // Slow oscillator model; held stopped while disabled to save power
  logic [PW-1:0] slow_cnt_q;
  logic slow_tick_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      slow_cnt_q <= '0;
      slow_tick_q <= 1'b0;
      slow_clk_o <= 1'b0;
    end else if (!clk_en) begin // RL1
      slow_cnt_q <= '0;
      slow_tick_q <= 1'b0;
      slow_clk_o <= 1'b0;
    end else if (slow_cnt_q >= slow_per - PW'(1)) begin // RL2
      slow_cnt_q <= '0;
      slow_tick_q <= 1'b1;
      slow_clk_o <= 1'b1;
    end else begin
      slow_cnt_q <= slow_cnt_q + PW'(1);
      slow_tick_q <= 1'b0;
      if (slow_cnt_q == (slow_per >> 1)) begin
        slow_clk_o <= 1'b0;
      end
    end
  end

  // Trim and pin enable outputs follow their registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      slow_clock_trim_o <= sct_pkg::SCT_RST_SLOW_CTRL[5:0];
      fast_clock_trim_o <= sct_pkg::SCT_RST_FAST_TRIM[7:0];
      irq_pin_input_enable_o <= 1'b0;
      external_sync_enable_o <= 1'b0;
    end else begin
      slow_clock_trim_o <= slow_trim; // RL3
      fast_clock_trim_o <= fast_trim_q[sct_pkg::SCT_FAST_TRIM_MSB:0]; // RL4
      irq_pin_input_enable_o <= pin_ie; // RL7
      external_sync_enable_o <= ext_sync_q[sct_pkg::SCT_BIT_EXT_SYNC_EN]; // RL10
    end
  end

  // Pin synchroniser; the second and third stages feed the edge detector
  logic pin_s1_q;
  logic pin_s2_q;
  logic pin_s3_q;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= irq_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q; // Tracks while disabled: enabling on a high pin is no edge
    end
  end

  logic pin_rise;
  assign pin_rise = pin_ie & pin_s2_q & ~pin_s3_q; // RL6 RL7

  // Sample cycle start: divider of slow ticks or external trigger
  logic [17:0] div_cnt_q;
  logic [17:0] div_end;
  assign div_end = {period_div_q, 2'b00}; // RL11
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_cnt_q <= '0;
      sample_start_o <= 1'b0;
    end else if (sync_src) begin
      div_cnt_q <= '0;
      sample_start_o <= pin_rise; // RL6
    end else if (slow_tick_q && div_end != 18'h00000) begin // RL5
      if (div_cnt_q >= div_end - 18'h00001) begin // RL11
        div_cnt_q <= '0;
        sample_start_o <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + 18'h00001;
        sample_start_o <= 1'b0;
      end
    end else begin
      sample_start_o <= 1'b0;
    end
  end

  // Ratio calculation: fast-reference cycles over a window of slow ticks
  logic start_bit;
  logic start_prev_q;
  sct_pkg::sct_ratio_st_t ratio_st_q;
  logic [RES_W-1:0] ratio_acc_q;
  logic [7:0] win_q;
  assign start_bit = ratio_ctrl_q[sct_pkg::SCT_BIT_RATIO_START];
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      start_prev_q <= 1'b0;
      ratio_st_q <= sct_pkg::SCT_R_IDLE;
      ratio_acc_q <= '0;
      ratio_res_q <= '0;
      win_q <= 8'h00;
      ratio_busy_o <= 1'b0;
    end else begin
      start_prev_q <= start_bit;
      case (ratio_st_q)
        sct_pkg::SCT_R_IDLE: begin
          // Level held high does not restart; host must clear it first
          if (start_bit && !start_prev_q && clk_en) begin // RL8 RL9 RL12
            ratio_st_q <= sct_pkg::SCT_R_RUN;
            ratio_acc_q <= '0;
            win_q <= 8'h00;
            ratio_busy_o <= 1'b1;
          end
        end
        sct_pkg::SCT_R_RUN: begin
          ratio_acc_q <= ratio_acc_q + RES_W'(1);
          if (slow_tick_q) begin
            win_q <= win_q + 8'h01;
            if (win_q == 8'(RATIO_SLOW_TICKS - 1)) begin
              ratio_res_q <= ratio_acc_q; // RL12
              ratio_st_q <= sct_pkg::SCT_R_IDLE;
              ratio_busy_o <= 1'b0;
            end
          end
          if (!clk_en) begin // No slow clock: abandon, keep old result
            ratio_st_q <= sct_pkg::SCT_R_IDLE;
            ratio_busy_o <= 1'b0;
          end
        end
        default: ratio_st_q <= sct_pkg::SCT_R_IDLE;
      endcase
    end
  end

endmodule : sct_core

`default_nettype wire

// ==== sim/sct_core_chk.sv ====
// Port checker for the sample clock trim and sync core
`timescale 1ns/1ps
`default_nettype none
module sct_core_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire sct_pkg::sct_wreq_t wreq_i,
  input wire logic rd_i,
  input wire logic rd_valid_o,
  input wire logic slow_clk_o,
  input wire logic [5:0] slow_clock_trim_o,
  input wire logic [7:0] fast_clock_trim_o,
  input wire logic irq_pin_input_enable_o,
  input wire logic sample_start_o,
  input wire logic ratio_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Register write to one offset
  sequence wr_at(a);
    wreq_i.wr && wreq_i.addr == a;
  endsequence
  rd_answer_a: assert property (rd_i |=> rd_valid_o) else $error("read not answered");
  rd_cause_a: assert property (rd_valid_o |-> $past(rd_i)) else $error("stray read valid");
  clk_gate_a: assert property (wr_at(8'h4B) ##0 !wreq_i.wdata[7] |=> ##1 !slow_clk_o [*4])
    else $error("slow clock runs while disabled");
  slow_trim_a: assert property (wr_at(8'h4B) |=> ##1
    slow_clock_trim_o == $past(wreq_i.wdata[5:0], 2)) else $error("slow trim not taken");
  fast_trim_a: assert property (wr_at(8'h4D) |=> ##1
    fast_clock_trim_o == $past(wreq_i.wdata[7:0], 2)) else $error("fast trim not taken");
  pin_ie_a: assert property (wr_at(8'h4F) |=> ##1
    irq_pin_input_enable_o == $past(wreq_i.wdata[1], 2)) else $error("pin enable not taken");
  start_pulse_a: assert property (sample_start_o |=> !sample_start_o)
    else $error("sample start longer than one cycle");
  ratio_go_a: assert property ($rose(ratio_busy_o) |->
    $past(wreq_i.wr && wreq_i.addr == 8'h50 && wreq_i.wdata[5], 2))
    else $error("ratio started without a start write");
endmodule : sct_core_chk
`default_nettype wire

// ==== sim/sct_host.sv ====
// Host model driving the register port of the clock control core
`timescale 1ns/1ps
`default_nettype none
module sct_host (
  // Clock and read answer
  input wire logic clk_i,
  input wire logic [15:0] rd_data_i,
  input wire logic rd_valid_i,
  // Requests
  output var sct_pkg::sct_wreq_t wreq_o,
  output var logic rd_o,
  output var logic [7:0] rd_addr_o
);
  // Idle bus at time zero
  initial begin
    wreq_o = '0;
    rd_o = 1'b0;
    rd_addr_o = 8'h00;
  end
  // One-cycle write, held until the taking edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #1 wreq_o = {1'b1, a, d};
    @(posedge clk_i);
    #1 wreq_o = {1'b0, ~a, ~d};
  endtask : wr
  // Read pulse, data taken one cycle later
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    #1 rd_o = 1'b1;
    rd_addr_o = a;
    @(posedge clk_i);
    #1 rd_o = 1'b0;
    d = rd_valid_i ? rd_data_i : 16'hDEAD;
  endtask : rd
  // Sync source and its companion enable always written together
  task automatic ext_sync(input logic on, input logic ie);
    wr(8'h38, {1'b0, on, 14'h0000});
    wr(8'h4F, {13'h0412, on, ie, 1'b0});
  endtask : ext_sync
  // Clear before set so a fresh start edge is seen
  task automatic ratio_go;
    wr(8'h50, 16'h0000);
    wr(8'h50, 16'h0020);
  endtask : ratio_go
endmodule : sct_host
`default_nettype wire

// ==== sim/sct_core_tb.sv ====
// Self-checking bench for the clock control core
`timescale 1ns/1ps
`default_nettype none
module sct_core_tb;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic irq = 1'b0;
  sct_pkg::sct_wreq_t wreq;
  logic rd, rd_valid, slow_clk, pin_ie, ext_en, start, busy;
  logic [7:0] rd_addr, fast_trim;
  logic [5:0] slow_trim;
  logic [15:0] rd_data, v;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  // Free-running system clock
  always #50 clk_i = ~clk_i;
  sct_core #(.RATIO_SLOW_TICKS(1)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wreq_i(wreq),
    .rd_i(rd), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
    .irq_pin_i(irq), .slow_clk_o(slow_clk), .slow_clock_trim_o(slow_trim),
    .fast_clock_trim_o(fast_trim), .irq_pin_input_enable_o(pin_ie),
    .external_sync_enable_o(ext_en), .sample_start_o(start), .ratio_busy_o(busy));
  sct_host host (.clk_i(clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .wreq_o(wreq),
    .rd_o(rd), .rd_addr_o(rd_addr));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("%0d compared, %0d mismatched", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // Count cycles until a sample start; a required one that never comes ends the run
  task automatic wait_start(input int lim, input bit must);
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (start !== 1'b1 && n < lim);
    if (must && n >= lim) begin
      n_mismatch++;
      $display("Error %0t: no sample start", $time);
      complete_run();
    end
  endtask : wait_start
  task automatic t_regs;
    logic [7:0] a [8] = '{8'h12, 8'h38, 8'h4B, 8'h4D, 8'h4E, 8'h4F, 8'h50, 8'h01};
    logic [15:0] e [8] = '{16'h0028, 16'h0000, 16'h2612, 16'h425E, 16'h0060, 16'h2090,
      16'h0000, 16'h0000};
    for (int i = 0; i < 8; i++) begin
      host.rd(a[i], v);
      chk(v, e[i]);
    end
    chk({10'h000, slow_trim}, 16'h0012);
    chk({8'h00, fast_trim}, 16'h005E);
    host.wr(8'h0A, 16'hFFFF);
    host.rd(8'h0A, v);
    chk(v, 16'h0000);
    $display("reset values done");
  endtask : t_regs
  task automatic t_trim;
    host.wr(8'h4B, 16'h263F);
    host.wr(8'h4D, 16'h42FF);
    @(posedge clk_i);
    #1 chk({10'h000, slow_trim}, 16'h003F);
    chk({8'h00, fast_trim}, 16'h00FF);
    host.wr(8'h4D, 16'h4200);
    @(posedge clk_i);
    #1 chk({8'h00, fast_trim}, 16'h0000);
    $display("trim done");
  endtask : t_trim
  task automatic t_ext;
    host.ext_sync(1'b1, 1'b1);
    irq = 1'b1;
    wait_start(8, 1'b1);
    chk(n[15:0], 16'h0003);
    chk({14'h0000, ext_en, pin_ie}, 16'h0003);
    irq = 1'b0;
    host.ext_sync(1'b1, 1'b0);
    irq = 1'b1;
    wait_start(20, 1'b0);
    chk(n[15:0], 16'h0014);
    irq = 1'b0;
    host.ext_sync(1'b0, 1'b0);
    $display("external trigger done");
  endtask : t_ext
  task automatic t_int;
    host.wr(8'h12, 16'h0001);
    host.wr(8'h4B, 16'h26A2);
    wait_start(3000, 1'b1);
    wait_start(3000, 1'b1);
    chk(n[15:0], 16'd1248);
    chk({15'h0000, slow_clk}, 16'h0001);
    host.wr(8'h4B, 16'h26A8);
    wait_start(3000, 1'b1);
    wait_start(3000, 1'b1);
    chk(n[15:0], 16'd1392);
    host.wr(8'h4B, 16'h2622);
    wait_start(3000, 1'b0);
    chk(n[15:0], 16'd3000);
    chk({15'h0000, slow_clk}, 16'h0000);
    $display("internal timing done");
  endtask : t_int
  task automatic t_ratio;
    logic [15:0] w;
    host.wr(8'h4B, 16'h26A2);
    host.ratio_go();
    @(posedge clk_i);
    #1 chk({15'h0000, busy}, 16'h0001);
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(posedge clk_i);
      #1 n++;
    end
    if (n >= 1000) begin
      chk(16'hFFFF, 16'h0000);
      complete_run();
    end
    host.rd(8'h0A, v);
    chk({15'h0000, v > 16'h0000 && v <= 16'd313}, 16'h0001);
    host.wr(8'h50, 16'h0020);
    repeat (2) @(posedge clk_i);
    #1 chk({15'h0000, busy}, 16'h0000);
    host.rd(8'h0A, w);
    chk(w, v);
    $display("ratio done");
  endtask : t_ratio
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    t_regs();
    t_trim();
    t_ext();
    t_int();
    t_ratio();
    complete_run();
  end
endmodule : sct_core_tb
bind sct_core sct_core_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .wreq_i(wreq_i),
  .rd_i(rd_i), .rd_valid_o(rd_valid_o), .slow_clk_o(slow_clk_o),
  .slow_clock_trim_o(slow_clock_trim_o), .fast_clock_trim_o(fast_clock_trim_o),
  .irq_pin_input_enable_o(irq_pin_input_enable_o), .sample_start_o(sample_start_o),
  .ratio_busy_o(ratio_busy_o));
`default_nettype wire
